// ===== hdl/pfm_pin_hold.sv
`timescale 1ns/1ps
module pfm_pin_hold (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire pfm_pkg::pfm_power_mode_e mode_in,
  input wire pfm_pkg::pfm_pin_drive_s live_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_out,
  output logic [7:0] pullup_out
);

  // ---------------------------------------------------------------------------
  // Low-power hold of the pin state
  // ---------------------------------------------------------------------------
  pfm_pkg::pfm_pin_drive_s held_ff;
  logic hold_now;
  logic standby_now;

  always_comb begin
    hold_now = 1'b0;
    standby_now = 1'b0;
    case (mode_in)
      pfm_pkg::PFM_MODE_SLEEP, pfm_pkg::PFM_MODE_SUBSLEEP, pfm_pkg::PFM_MODE_WATCH: begin
        hold_now = 1'b1;
      end
      pfm_pkg::PFM_MODE_STANDBY: begin
        standby_now = 1'b1;
      end
      default: begin
        hold_now = 1'b0;
      end
    endcase
  end

  // The snapshot tracks live state while running, and freezes while held.
  // Reset clears it, so pins are undriven with pull-ups off.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held_ff <= '0; // R10 R13
    end else if (!hold_now && !standby_now) begin
      held_ff <= live_in;
    end
  end

  // Standby floats every pin without pull-up; a pin with pull-up on reads high, which the
  // pad shows by driving high so the level is defined even without a resistor.
  always_comb begin
    if (standby_now) begin
      pin_oe_out = held_ff.pullup_on; // R10 R11
      pin_out = held_ff.pullup_on; // R11
      pullup_out = held_ff.pullup_on;
    end else if (hold_now) begin
      pin_oe_out = held_ff.drive_en; // R10
      pin_out = held_ff.drive_val;
      pullup_out = held_ff.pullup_on;
    end else begin
      pin_oe_out = held_ff.drive_en; // R10
      pin_out = held_ff.drive_val;
      pullup_out = held_ff.pullup_on;
    end
  end

endmodule

// ===== hdl/pfm_pin_select.sv
`timescale 1ns/1ps
module pfm_pin_select (
  input wire logic [7:0] func_sel_in,
  input wire logic [7:0] dir_in,
  input wire logic [7:0] latch_in,
  input wire logic [7:0] pullup_sel_in,
  input wire pfm_pkg::pfm_periph_in_s periph_in,
  output pfm_pkg::pfm_pin_drive_s drive_out
);

  // ---------------------------------------------------------------------------
  // Per-pin function selection
  // ---------------------------------------------------------------------------

  // Pins 7 to 3 are inputs in their alternate function, so the driver is off.
  // Pins 2 to 0 drive the timer outputs whatever the direction bit says.
  always_comb begin
    drive_out.drive_en = dir_in & ~func_sel_in; // R2 R4 R16
    drive_out.drive_val = latch_in; // R16
    if (func_sel_in[pfm_pkg::FSEL_TF_HIGH]) begin
      drive_out.drive_en[pfm_pkg::FSEL_TF_HIGH] = 1'b1; // R9 R18
      drive_out.drive_val[pfm_pkg::FSEL_TF_HIGH] = periph_in.timer_f_high_out; // R18
    end
    if (func_sel_in[pfm_pkg::FSEL_TF_LOW]) begin
      drive_out.drive_en[pfm_pkg::FSEL_TF_LOW] = 1'b1; // R9 R18
      drive_out.drive_val[pfm_pkg::FSEL_TF_LOW] = periph_in.timer_f_low_out; // R18
    end
    if (func_sel_in[pfm_pkg::FSEL_WATCH]) begin
      drive_out.drive_en[pfm_pkg::FSEL_WATCH] = 1'b1; // R1 R9 R18
      drive_out.drive_val[pfm_pkg::FSEL_WATCH] = periph_in.watch_clock_out; // R1
    end
    // The pull-up follows only the direction and pull-up bits.
    drive_out.pullup_on = ~dir_in & pullup_sel_in; // R12
  end

endmodule

// ===== hdl/pfm_pkg.sv
package pfm_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h0;
  localparam logic [3:0] OFS_DIRECTION = 4'h1;
  localparam logic [3:0] OFS_PULLUP = 4'h2;
  localparam logic [3:0] OFS_FUNCTION = 4'h3;
  localparam logic [3:0] OFS_POWER_MODE = 4'h4;
  localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_FUNCTION = 8'h00;
  localparam logic [7:0] DIR_READ_VALUE = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------------------
  // Function select bit positions
  // ---------------------------------------------------------------------------
  localparam int FSEL_INT_C = 7;
  localparam int FSEL_INT_B = 6;
  localparam int FSEL_INT_A = 5;
  localparam int FSEL_INT_D = 4;
  localparam int FSEL_CAPTURE = 3;
  localparam int FSEL_TF_HIGH = 2;
  localparam int FSEL_TF_LOW = 1;
  localparam int FSEL_WATCH = 0;

  // ---------------------------------------------------------------------------
  // Peripheral field values
  // ---------------------------------------------------------------------------
  localparam logic [2:0] TF_CLK_SEL_EXT = 3'h0;
  localparam logic [2:0] TC_MODE_EVENT = 3'h7;

  // Operating modes of the chip, as seen by the port.
  typedef enum logic [2:0] {
    PFM_MODE_ACTIVE,
    PFM_MODE_SUBACTIVE,
    PFM_MODE_SLEEP,
    PFM_MODE_SUBSLEEP,
    PFM_MODE_WATCH,
    PFM_MODE_STANDBY
  } pfm_power_mode_e;

  // Per-pin drive request from the selection logic.
  typedef struct packed {
    logic [7:0] drive_en;
    logic [7:0] drive_val;
    logic [7:0] pullup_on;
  } pfm_pin_drive_s;

  // Peripheral signals that go into the port from the timers and converter.
  typedef struct packed {
    logic [2:0] timer_f_clock_sel;
    logic [2:0] timer_c_mode_field;
    logic adc_trigger_enable;
    logic timer_f_high_out;
    logic timer_f_low_out;
    logic watch_clock_out;
  } pfm_periph_in_s;

endpackage

// ===== hdl/pfm_port1.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// R1: Function bit 0 clear gives general I/O; set drives the watch clock out on pin 0.
// R2: Pin 7 is I/O by direction, or interrupt input; also timer-F clock when selected.
// R3: Software clears the interrupt enable when pin 7 clocks timer F.
// R4: Pin 6 is interrupt input when selected, else I/O by direction bit.
// R5: Pin 5 is interrupt input; also timer-C event input when mode is 111.
// R6: Software clears the interrupt enable when pin 5 feeds timer-C events.
// R7: Pin 4 is interrupt input; also converter trigger when trigger enable set.
// R8: Software clears the interrupt enable when pin 4 triggers the converter.
// R9: Pins 3 to 0 take their alternate function regardless of direction bit.
// R10: Pins float in reset and standby, hold in sleep modes, run otherwise; in standby, pins with pull-up on are driven high instead.
// R11: In standby, a pin with pull-up on shows a high level.
// R12: Pull-up is on only with direction 0 and pull-up bit 1.
// R13: Every pull-up is off after reset.
// R14: Port read returns latch for output pins and pin level for inputs.
// R15: Direction register is write-only, resets to zero, reads as all ones.
// R16: Direction and latch act only on pins selected as general I/O.
// R17: Function select register is read/write, 8 bits, reset to zero.
// R18: A selected alternate output enables the driver from the timer signal.
module pfm_port1 (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [pfm_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [pfm_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [pfm_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_out,
  output logic [7:0] pullup_out,
  input wire pfm_pkg::pfm_periph_in_s periph_in,
  output logic ext_int_line_a_out,
  output logic ext_int_line_b_out,
  output logic ext_int_line_c_out,
  output logic ext_int_line_d_out,
  output logic timer_f_clock_in_out,
  output logic timer_c_event_in_out,
  output logic adc_ext_trigger_in_out,
  output logic capture_in_out
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [7:0] port_output_latch_ff;
  logic [7:0] pin_direction_reg_ff;
  logic [7:0] pullup_select_reg_ff;
  logic [7:0] pin_function_select_reg_ff;
  pfm_pkg::pfm_power_mode_e power_mode_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;
  pfm_pkg::pfm_pin_drive_s live_drive;

  // Address match helper used by the write decoders; the read decoder uses a case.
  function automatic logic hit(input logic [pfm_pkg::ADDR_W-1:0] addr,
                               input logic [pfm_pkg::ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Output latch, software written.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_output_latch_ff <= pfm_pkg::RST_OUTPUT_LATCH;
    end else if (reg_wr_in && hit(reg_addr_in, pfm_pkg::OFS_OUTPUT_LATCH)) begin
      port_output_latch_ff <= reg_wdata_in;
    end
  end

  // Direction register; write-only, resets to all inputs.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_direction_reg_ff <= pfm_pkg::RST_DIRECTION; // R15
    end else if (reg_wr_in && hit(reg_addr_in, pfm_pkg::OFS_DIRECTION)) begin
      pin_direction_reg_ff <= reg_wdata_in;
    end
  end

  // Pull-up select, reset off so no pin is pulled after reset.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pullup_select_reg_ff <= pfm_pkg::RST_PULLUP; // R13
    end else if (reg_wr_in && hit(reg_addr_in, pfm_pkg::OFS_PULLUP)) begin
      pullup_select_reg_ff <= reg_wdata_in;
    end
  end

  // Function select register.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_function_select_reg_ff <= pfm_pkg::RST_FUNCTION; // R17
    end else if (reg_wr_in && hit(reg_addr_in, pfm_pkg::OFS_FUNCTION)) begin
      pin_function_select_reg_ff <= reg_wdata_in; // R17
    end
  end

  // Operating mode, set by the power controller's software. Unknown codes
  // fall back to active so a bad write never parks the port.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_mode_ff <= pfm_pkg::PFM_MODE_ACTIVE;
    end else if (reg_wr_in && hit(reg_addr_in, pfm_pkg::OFS_POWER_MODE)) begin
      if (reg_wdata_in[2:0] <= 3'(pfm_pkg::PFM_MODE_STANDBY)) begin
        power_mode_ff <= pfm_pkg::pfm_power_mode_e'(reg_wdata_in[2:0]);
      end else begin
        power_mode_ff <= pfm_pkg::PFM_MODE_ACTIVE;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------------------

  // Port read mixes latch and pin level per bit; the pin value is taken as
  // synchronous, so no synchroniser sits in front of it.
  always_comb begin
    nxt_rdata = pfm_pkg::UNMAPPED_READ;
    case (reg_addr_in)
      pfm_pkg::OFS_OUTPUT_LATCH: begin
        nxt_rdata = (pin_direction_reg_ff & port_output_latch_ff)
                  | (~pin_direction_reg_ff & pin_in); // R14
      end
      pfm_pkg::OFS_DIRECTION: begin
        nxt_rdata = pfm_pkg::DIR_READ_VALUE; // R15
      end
      pfm_pkg::OFS_PULLUP: begin
        nxt_rdata = pullup_select_reg_ff;
      end
      pfm_pkg::OFS_FUNCTION: begin
        nxt_rdata = pin_function_select_reg_ff; // R17
      end
      pfm_pkg::OFS_POWER_MODE: begin
        nxt_rdata = {5'h00, power_mode_ff};
      end
      default: begin
        nxt_rdata = pfm_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe; the bus is quiet otherwise.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_ff <= pfm_pkg::UNMAPPED_READ;
    end else if (reg_rd_in) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= pfm_pkg::UNMAPPED_READ;
    end
  end

  assign reg_rdata_out = reg_rdata_ff;

  // ---------------------------------------------------------------------------
  // Alternate input routing
  // ---------------------------------------------------------------------------

  // Interrupt lines idle high when not selected, since the lines are active low
  // at the controller; shared inputs also feed the timers and converter.
  always_comb begin
    ext_int_line_c_out = pin_function_select_reg_ff[pfm_pkg::FSEL_INT_C]
                         ? pin_in[pfm_pkg::FSEL_INT_C] : 1'b1; // R2
    ext_int_line_b_out = pin_function_select_reg_ff[pfm_pkg::FSEL_INT_B]
                         ? pin_in[pfm_pkg::FSEL_INT_B] : 1'b1; // R4
    ext_int_line_a_out = pin_function_select_reg_ff[pfm_pkg::FSEL_INT_A]
                         ? pin_in[pfm_pkg::FSEL_INT_A] : 1'b1; // R5
    ext_int_line_d_out = pin_function_select_reg_ff[pfm_pkg::FSEL_INT_D]
                         ? pin_in[pfm_pkg::FSEL_INT_D] : 1'b1; // R7
    timer_f_clock_in_out = pin_function_select_reg_ff[pfm_pkg::FSEL_INT_C]
                           && (periph_in.timer_f_clock_sel == pfm_pkg::TF_CLK_SEL_EXT)
                           && pin_in[pfm_pkg::FSEL_INT_C]; // R2
    timer_c_event_in_out = pin_function_select_reg_ff[pfm_pkg::FSEL_INT_A]
                           && (periph_in.timer_c_mode_field == pfm_pkg::TC_MODE_EVENT)
                           && pin_in[pfm_pkg::FSEL_INT_A]; // R5
    adc_ext_trigger_in_out = pin_function_select_reg_ff[pfm_pkg::FSEL_INT_D]
                             ? (periph_in.adc_trigger_enable ? pin_in[pfm_pkg::FSEL_INT_D]
                                                             : 1'b1)
                             : 1'b1; // R7
    capture_in_out = pin_function_select_reg_ff[pfm_pkg::FSEL_CAPTURE]
                     && pin_in[pfm_pkg::FSEL_CAPTURE]; // R9
  end

  // ---------------------------------------------------------------------------
  // Pin drive and low-power hold
  // ---------------------------------------------------------------------------
  pfm_pin_select u_select (
    .func_sel_in(pin_function_select_reg_ff),
    .dir_in(pin_direction_reg_ff),
    .latch_in(port_output_latch_ff),
    .pullup_sel_in(pullup_select_reg_ff),
    .periph_in(periph_in),
    .drive_out(live_drive)
  );

  pfm_pin_hold u_hold (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .mode_in(power_mode_ff),
    .live_in(live_drive),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out),
    .pullup_out(pullup_out)
  );

endmodule

// ===== sim/pfm_pad_model.sv
`timescale 1ns/1ps
module pfm_pad_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  input wire logic [7:0] pullup_in,
  input wire logic [7:0] ext_val_in,
  input wire logic [7:0] ext_en_in,
  output logic [7:0] level_out
);
  logic float_ff = 1'b0;
  // A floating pad flips every cycle, so a stale level never looks valid.
  always_ff @(posedge sys_clk_in) begin
    float_ff <= ~float_ff;
  end
  // The device driver wins, then an outside driver, then the pull-up.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_in[i]) level_out[i] = pin_out_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pullup_in[i]) level_out[i] = 1'b1;
      else level_out[i] = float_ff;
    end
  end
endmodule

// ===== sim/pfm_port1_checker.sv
`timescale 1ns/1ps
module pfm_port1_checker (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_out,
  input wire logic [7:0] pullup_out,
  input wire pfm_pkg::pfm_periph_in_s periph_in,
  input wire logic timer_f_clock_in_out,
  input wire logic timer_c_event_in_out,
  input wire logic adc_ext_trigger_in_out,
  input wire logic capture_in_out
);
  logic [7:0] dir_ff;
  logic [7:0] lat_ff;
  logic [7:0] fsel_ff;
  logic [7:0] rd_exp;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Shadows of what software wrote, since direction cannot be read back.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_ff <= 8'h00;
      lat_ff <= 8'h00;
      fsel_ff <= 8'h00;
    end else if (reg_wr_in) begin
      if (reg_addr_in == pfm_pkg::OFS_DIRECTION) dir_ff <= reg_wdata_in;
      if (reg_addr_in == pfm_pkg::OFS_OUTPUT_LATCH) lat_ff <= reg_wdata_in;
      if (reg_addr_in == pfm_pkg::OFS_FUNCTION) fsel_ff <= reg_wdata_in;
    end
  end
  // Output pins read the latch, input pins read the pad.
  assign rd_exp = (dir_ff & lat_ff) | (~dir_ff & pin_in);
  AST_TF_CLOCK: assert property (
    timer_f_clock_in_out |-> fsel_ff[7] && pin_in[7]
      && periph_in.timer_f_clock_sel == pfm_pkg::TF_CLK_SEL_EXT)
    else $error("timer F clock without its cause");
  AST_TC_EVENT: assert property (
    timer_c_event_in_out |-> fsel_ff[5] && pin_in[5]
      && periph_in.timer_c_mode_field == pfm_pkg::TC_MODE_EVENT)
    else $error("timer C event without its cause");
  AST_ADC_TRIG: assert property (
    !adc_ext_trigger_in_out |-> fsel_ff[4] && !pin_in[4] && periph_in.adc_trigger_enable)
    else $error("converter trigger without its cause");
  AST_CAPTURE: assert property (
    capture_in_out |-> fsel_ff[3] && pin_in[3])
    else $error("capture input without a high pin");
  AST_PULL_EXCL: assert property (
    ((pullup_out & pin_oe_out & ~pin_out) & 8'hf8) == 8'h00)
    else $error("pull-up on while driving low");
  AST_RST_RELEASE: assert property (
    $rose(rst_n_in) |-> pin_oe_out == 8'h00 && pullup_out == 8'h00)
    else $error("pins not quiet after reset");
  AST_DIR_READ: assert property (
    reg_rd_in && reg_addr_in == pfm_pkg::OFS_DIRECTION |=> reg_rdata_out == 8'hff)
    else $error("direction read not all ones");
  AST_FSEL_READ: assert property (
    reg_rd_in && reg_addr_in == pfm_pkg::OFS_FUNCTION |=> reg_rdata_out == $past(fsel_ff))
    else $error("function select read back wrong");
  AST_PORT_READ: assert property (
    reg_rd_in && reg_addr_in == pfm_pkg::OFS_OUTPUT_LATCH |=> reg_rdata_out == $past(rd_exp))
    else $error("port read mixes latch and pad wrongly");
  // Main scenarios that must be reached.
  cover property (timer_f_clock_in_out);
  cover property (!adc_ext_trigger_in_out);
  cover property (reg_rd_in && reg_addr_in == pfm_pkg::OFS_DIRECTION);
endmodule

bind pfm_port1 pfm_port1_checker u_pfm_port1_checker (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .pullup_out(pullup_out), .periph_in(periph_in),
  .timer_f_clock_in_out(timer_f_clock_in_out), .timer_c_event_in_out(timer_c_event_in_out),
  .adc_ext_trigger_in_out(adc_ext_trigger_in_out), .capture_in_out(capture_in_out)
);

// ===== sim/pfm_port1_tb.sv
`timescale 1ns/1ps
module pfm_port1_tb;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] ext_val = 8'h3a;
  logic [7:0] ext_en = 8'hff;
  pfm_pkg::pfm_periph_in_s periph_in = '0;
  logic [7:0] reg_rdata_out, pin_in, pin_out, pin_oe_out, pullup_out, ev, ex;
  logic int_c, int_b, int_a, int_d, tf_clk, tc_evt, adc_trg, cap_in;
  int miscompares = 0;
  int checks = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  pfm_port1 u_pfm_port1 (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .pullup_out(pullup_out), .periph_in(periph_in),
    .ext_int_line_a_out(int_a), .ext_int_line_b_out(int_b), .ext_int_line_c_out(int_c),
    .ext_int_line_d_out(int_d), .timer_f_clock_in_out(tf_clk),
    .timer_c_event_in_out(tc_evt), .adc_ext_trigger_in_out(adc_trg), .capture_in_out(cap_in)
  );
  pfm_pad_model u_pfm_pad_model (
    .sys_clk_in(sys_clk_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
    .pullup_in(pullup_out), .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(pin_in)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Writes leave the strobe up, so back-to-back writes need no gap.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
  endtask
  // Ends at a falling edge so that registered outputs have settled.
  task automatic idle(input int n);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    repeat (n) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(reg_rdata_out, exp);
    @(posedge sys_clk_in);
  endtask
  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A hang costs a mismatch and still reaches the report.
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    miscompares++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    repeat (7) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk(pin_oe_out, 8'h00);
    chk(pullup_out, 8'h00);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    rd(pfm_pkg::OFS_OUTPUT_LATCH, 8'h3a);
    rd(pfm_pkg::OFS_DIRECTION, 8'hff);
    rd(pfm_pkg::OFS_PULLUP, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    rd(pfm_pkg::OFS_FUNCTION, 8'h00);
    ext_val <= 8'h38;
    ext_en <= 8'hf8;
    wr(pfm_pkg::OFS_DIRECTION, 8'h07);
    wr(pfm_pkg::OFS_OUTPUT_LATCH, 8'ha5);
    wr(pfm_pkg::OFS_PULLUP, 8'hff);
    idle(3);
    chk(pin_oe_out, 8'h07);
    chk(pin_out & 8'h07, 8'h05);
    chk(pullup_out, 8'hf8);
    chk({int_c, int_b, int_a, int_d, tf_clk, tc_evt, adc_trg, cap_in}, 8'hf2);
    @(posedge sys_clk_in);
    rd(pfm_pkg::OFS_OUTPUT_LATCH, 8'h3d);
    // Sleep, subsleep and watch must freeze the pins; subactive runs.
    for (int m = 2; m < 5; m++) begin
      wr(pfm_pkg::OFS_POWER_MODE, 8'(m));
      wr(pfm_pkg::OFS_OUTPUT_LATCH, 8'h5a);
      wr(pfm_pkg::OFS_PULLUP, 8'h00);
      idle(3);
      chk(pin_out & 8'h07, 8'h05);
      chk(pullup_out, 8'hf8);
      @(posedge sys_clk_in);
      wr(pfm_pkg::OFS_POWER_MODE, 8'h01);
      idle(3);
      chk(pin_out & 8'h07, 8'h02);
      @(posedge sys_clk_in);
      wr(pfm_pkg::OFS_OUTPUT_LATCH, 8'ha5);
      wr(pfm_pkg::OFS_PULLUP, 8'hff);
      idle(3);
      @(posedge sys_clk_in);
    end
    ext_en <= 8'h00;
    wr(pfm_pkg::OFS_POWER_MODE, 8'h05);
    idle(3);
    chk(pin_oe_out, 8'hf8);
    chk(pin_in & 8'hf8, 8'hf8);
    @(posedge sys_clk_in);
    rd(pfm_pkg::OFS_POWER_MODE, 8'h05);
    ext_en <= 8'hf8;
    periph_in <= {3'h0, 3'h7, 4'hd};
    wr(pfm_pkg::OFS_POWER_MODE, 8'h00);
    wr(pfm_pkg::OFS_DIRECTION, 8'hc7);
    wr(pfm_pkg::OFS_FUNCTION, 8'hff);
    idle(3);
    chk(pin_oe_out, 8'h07);
    chk(pin_out & 8'h07, 8'h05);
    @(posedge sys_clk_in);
    rd(pfm_pkg::OFS_FUNCTION, 8'hff);
    rd(pfm_pkg::OFS_DIRECTION, 8'hff);
    // An unknown mode code must fall back to active so the port keeps running.
    wr(pfm_pkg::OFS_POWER_MODE, 8'h07);
    rd(pfm_pkg::OFS_POWER_MODE, 8'h00);
    // Pin levels against timer clock select, timer C mode and trigger enable.
    // Software keeps the shared interrupt enables cleared while pins feed the timers.
    for (int i = 0; i < 4; i++) begin
      ev = i[0] ? 8'hc0 : 8'h38;
      ex = {ev[7:4], ev[7] & !i[1], ev[5] & !i[1], i[1] | ev[4], ev[3]};
      ext_val <= ev;
      periph_in <= {2'b00, i[1], (i[1] ? 3'h6 : 3'h7), ~i[1], i[1], ~i[1], 1'b1};
      idle(2);
      chk({int_c, int_b, int_a, int_d, tf_clk, tc_evt, adc_trg, cap_in}, ex);
      chk(pin_out & 8'h07, {5'h00, i[1], ~i[1], 1'b1});
      @(posedge sys_clk_in);
    end
    print_verdict();
  end
endmodule
